// file: rtl/sfw_core.sv
`include "sfw_defs.svh"
module sfw_core import sfw_pkg::*; #(
   parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary value
   parameter logic [7:0] DEV_ID = 8'h3C, // Arbitrary value
   parameter logic [7:0] MEM_TYPE = 8'h40, // Arbitrary value
   parameter logic [7:0] CAPACITY = 8'h18, // Arbitrary value
   parameter logic [127:0] UNIQUE_ID = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210 // Arbitrary
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] io_i,
   output logic [3:0] io_o,
   output logic [3:0] io_oe,
   input wire logic quad_enable_bit,
   input wire logic busy,
   input wire logic soft_reset,
   output logic [23:0] mem_addr,
   input wire logic [7:0] mem_data,
   output sfw_wrap_t wrap_setting_bits,
   output logic cont_mode
);
   // ==============================
   // Pin synchronisers
   logic [1:0] cs_sync_q;
   logic [1:0] sck_sync_q;
   logic sck_d_q;
   logic [3:0] io_s1_q;
   logic [3:0] io_s2_q;
   logic sel;
   logic rise;
   logic fall;

   // Two flops on every pin, third for edge detection
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cs_sync_q <= 2'h3;
         sck_sync_q <= 2'h0;
         sck_d_q <= 1'b0;
         io_s1_q <= 4'h0;
         io_s2_q <= 4'h0;
      end else begin
         cs_sync_q <= {cs_sync_q[0], cs_n};
         sck_sync_q <= {sck_sync_q[0], sclk};
         sck_d_q <= sck_sync_q[1];
         io_s1_q <= io_i;
         io_s2_q <= io_s1_q;
      end
   end

   assign sel = ~cs_sync_q[1];
   assign rise = sel & sck_sync_q[1] & ~sck_d_q;
   assign fall = sel & ~sck_sync_q[1] & sck_d_q;

   // ==============================
   // Decode helpers
   function automatic logic is_quad(input logic [7:0] c);
      return c == `SFW_OP_QFR || c == `SFW_OP_QWR || c == `SFW_OP_ID4;
   endfunction

   function automatic logic [2:0] bus_w(input sfw_state_t s, input logic [7:0] c);
      if (s == SFW_OPC || s == SFW_WRAP) begin
         return 3'd1;
      end else if (is_quad(c)) begin
         return 3'd4;
      end else if (c == `SFW_OP_ID2) begin
         return 3'd2;
      end
      return 3'd1;
   endfunction

   function automatic logic [5:0] dummy_clks(input logic [7:0] c);
      case (c)
         `SFW_OP_QFR: return `SFW_DUM_QFR;
         `SFW_OP_QWR: return `SFW_DUM_QWR;
         `SFW_OP_ID4: return `SFW_DUM_ID4;
         default: return `SFW_DUM_UID;
      endcase
   endfunction

   // Next read address, confined to the section when wrapping
   function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap,
                                             input logic [1:0] len);
      logic [23:0] m;
      m = {18'h0, len == 2'h3, len >= 2'h2, len != 2'h0, 3'h7};
      if (wrap) begin
         return (a & ~m) | ((a + 24'h1) & m);
      end
      return a + 24'h1;
   endfunction

   // ==============================
   // Command sequencer
   sfw_state_t st_q;
   logic [7:0] cmd_q;
   logic [5:0] cnt_q;
   logic [23:0] sh_q;
   logic [23:0] sh_n;
   logic [2:0] w;
   logic [5:0] addr_clks;
   logic [7:0] opc;
   sfw_wrap_t wrap_q;
   logic cont_q;
   logic [7:0] cont_cmd_q;
   logic phase_end;

   // Incoming bits at the current width
   always_comb begin
      w = bus_w(st_q, cmd_q);
      case (w)
         3'd4: sh_n = {sh_q[19:0], io_s2_q};
         3'd2: sh_n = {sh_q[21:0], io_s2_q[1:0]};
         default: sh_n = {sh_q[22:0], io_s2_q[0]};
      endcase
      case (w)
         3'd4: addr_clks = `SFW_ADDR_CLK4;
         3'd2: addr_clks = `SFW_ADDR_CLK2;
         default: addr_clks = `SFW_ADDR_CLK1;
      endcase
      opc = sh_n[7:0];
      case (st_q)
         SFW_OPC: phase_end = cnt_q == `SFW_BYTE_CLK1 - 6'd1;
         SFW_ADDR: phase_end = cnt_q == addr_clks - 6'd1;
         SFW_MODE: phase_end = cnt_q == `SFW_MODE_CLK4 - 6'd1;
         SFW_DUMMY: phase_end = cnt_q == dummy_clks(cmd_q) - 6'd1;
         SFW_WRAP: phase_end = cnt_q == `SFW_BYTE_CLK1 - 6'd1;
         default: phase_end = 1'b0;
      endcase
   end

   // Phase stepping on rising serial clock
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_q <= SFW_OPC;
         cmd_q <= 8'h00;
         cnt_q <= 6'h00;
         sh_q <= 24'h0;
      end else if (!sel) begin
         st_q <= cont_q ? SFW_ADDR : SFW_OPC;
         cmd_q <= cont_cmd_q;
         cnt_q <= 6'h00;
         sh_q <= 24'h0;
      end else if (rise && st_q != SFW_DATA && st_q != SFW_IGN) begin
         sh_q <= sh_n;
         cnt_q <= phase_end ? 6'h00 : cnt_q + 6'd1;
         if (phase_end) begin
            case (st_q)
               SFW_OPC: begin
                  cmd_q <= opc;
                  case (opc)
                     `SFW_OP_WRAP, `SFW_OP_ID1, `SFW_OP_ID2: st_q <= SFW_ADDR;
                     `SFW_OP_QFR, `SFW_OP_QWR, `SFW_OP_ID4:
                        st_q <= quad_enable_bit ? SFW_ADDR : SFW_IGN;
                     `SFW_OP_STDID: st_q <= busy ? SFW_IGN : SFW_DATA;
                     `SFW_OP_UID: st_q <= SFW_DUMMY;
                     default: st_q <= SFW_IGN;
                  endcase
               end
               SFW_ADDR: begin
                  case (cmd_q)
                     `SFW_OP_WRAP: st_q <= SFW_WRAP;
                     `SFW_OP_QFR, `SFW_OP_QWR: st_q <= SFW_MODE;
                     `SFW_OP_ID4: st_q <= SFW_DUMMY;
                     default: st_q <= SFW_DATA;
                  endcase
               end
               SFW_MODE: st_q <= SFW_DUMMY;
               SFW_DUMMY: st_q <= SFW_DATA;
               default: st_q <= SFW_IGN;
            endcase
         end
      end
   end

   // ==============================
   // Wrap setting and continuous-read mode
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wrap_q <= '{len: `SFW_WRAP_LEN_RST, dis: `SFW_WRAP_DIS_RST};
      end else if (soft_reset) begin
         wrap_q <= '{len: `SFW_WRAP_LEN_RST, dis: `SFW_WRAP_DIS_RST};
      end else if (rise && st_q == SFW_WRAP && phase_end) begin
         wrap_q <= '{len: sh_n[6:5], dis: sh_n[4]};
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cont_q <= 1'b0;
         cont_cmd_q <= 8'h00;
      end else if (soft_reset) begin
         cont_q <= 1'b0;
      end else if (rise && st_q == SFW_MODE && phase_end) begin
         cont_q <= sh_n[5:4] == `SFW_CONT_CODE;
         cont_cmd_q <= cmd_q;
      end
   end

   // ==============================
   // Read pointer and output shifter
   logic [23:0] addr_q;
   logic [3:0] idx_q;
   logic [7:0] ob_q;
   logic [3:0] obc_q;
   logic [3:0] oe_q;
   logic [3:0] out_q;
   logic wrap_on;
   logic load;
   logic [7:0] src;
   logic [7:0] byte_n;

   always_comb begin
      wrap_on = !wrap_q.dis && (cmd_q == `SFW_OP_QFR || cmd_q == `SFW_OP_QWR);
      load = fall && st_q == SFW_DATA && obc_q == 4'h0;
      case (cmd_q)
         `SFW_OP_ID1, `SFW_OP_ID2, `SFW_OP_ID4:
            src = idx_q[0] ? DEV_ID : MFR_ID;
         `SFW_OP_STDID:
            src = idx_q == 4'h0 ? MFR_ID : (idx_q == 4'h1 ? MEM_TYPE : CAPACITY);
         `SFW_OP_UID: src = UNIQUE_ID[8'd127 - {idx_q, 3'h0} -: 8];
         default: src = mem_data;
      endcase
      byte_n = load ? src : ob_q;
   end

   // Address and identifier byte index
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         addr_q <= 24'h0;
         idx_q <= 4'h0;
      end else if (!sel) begin
         idx_q <= 4'h0;
      end else if (rise && st_q == SFW_ADDR && phase_end) begin
         addr_q <= sh_n;
         idx_q <= {3'h0, sh_n[0]};
      end else if (load) begin
         addr_q <= next_addr(addr_q, wrap_on, wrap_q.len);
         if (cmd_q == `SFW_OP_STDID && idx_q == 4'h2) begin
            idx_q <= 4'h0;
         end else begin
            idx_q <= idx_q + 4'h1;
         end
      end
   end

   // Drive data on falling serial clock
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ob_q <= 8'h00;
         obc_q <= 4'h0;
         oe_q <= 4'h0;
         out_q <= 4'h0;
      end else if (!sel) begin
         obc_q <= 4'h0;
         oe_q <= 4'h0;
      end else if (fall && st_q == SFW_DATA) begin
         case (w)
            3'd4: begin
               out_q <= byte_n[7:4];
               oe_q <= 4'hF;
               ob_q <= {byte_n[3:0], 4'h0};
            end
            3'd2: begin
               out_q <= {2'h0, byte_n[7:6]};
               oe_q <= 4'h3;
               ob_q <= {byte_n[5:0], 2'h0};
            end
            default: begin
               out_q <= {2'h0, byte_n[7], 1'b0};
               oe_q <= 4'h2;
               ob_q <= {byte_n[6:0], 1'b0};
            end
         endcase
         obc_q <= (load ? 4'h8 : obc_q) - {1'b0, w};
      end
   end

   assign io_o = out_q;
   assign io_oe = oe_q;
   assign mem_addr = addr_q;
   assign wrap_setting_bits = wrap_q;
   assign cont_mode = cont_q;

   // ==============================
   // Checks
   sequence deselect_s;
      !sel;
   endsequence

   sequence last_opc_s(logic [7:0] c);
      rise && st_q == SFW_OPC && phase_end && opc == c;
   endsequence

   property quiet_after_p;
      @(posedge sys_clk) disable iff (rst) deselect_s |=> io_oe == 4'h0 ##1 io_oe == 4'h0;
   endproperty

   busy_stdid_a: assert property (@(posedge sys_clk) disable iff (rst)
      last_opc_s(`SFW_OP_STDID) ##0 busy |=> st_q == SFW_IGN)
      else $error("identifier opcode accepted while busy");
   qe_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
      last_opc_s(`SFW_OP_QWR) ##0 !quad_enable_bit |=> st_q == SFW_IGN)
      else $error("quad word read accepted without quad enable");
   wrap_reset_a: assert property (@(posedge sys_clk) disable iff (rst)
      soft_reset |=> wrap_setting_bits.dis && wrap_setting_bits.len == 2'h0 && !cont_mode)
      else $error("software reset left volatile settings");
   deselect_quiet_a: assert property (quiet_after_p)
      else $error("output driven after deselect");
   wrap_section_a: assert property (@(posedge sys_clk) disable iff (rst)
      load && wrap_on |=> mem_addr[23:6] == $past(mem_addr[23:6]) &&
      mem_addr[2:0] == $past(mem_addr[2:0]) + 3'h1)
      else $error("wrapped burst left its section");
   linear_step_a: assert property (@(posedge sys_clk) disable iff (rst)
      load && !wrap_on && cmd_q == `SFW_OP_QWR |=> mem_addr == $past(mem_addr) + 24'h1)
      else $error("word read address did not step");
   word_dummy_a: assert property (@(posedge sys_clk) disable iff (rst)
      rise && st_q == SFW_DUMMY && cmd_q == `SFW_OP_QWR && cnt_q == 6'd1 |=> st_q == SFW_DATA)
      else $error("word read dummy length wrong");
   cont_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
      rise && st_q == SFW_MODE && phase_end && sh_n[5:4] == 2'h2 && !soft_reset
      |=> cont_mode)
      else $error("continuous mode not armed");
   cont_skip_a: assert property (@(posedge sys_clk) disable iff (rst)
      deselect_s ##0 cont_mode |=> st_q == SFW_ADDR)
      else $error("continuous mode did not skip opcode");
   mode_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
      deselect_s ##0 !cont_mode |=> st_q == SFW_OPC)
      else $error("opcode phase not restored");
   wrap_write_a: assert property (@(posedge sys_clk) disable iff (rst)
      rise && st_q == SFW_WRAP && phase_end && !soft_reset
      |=> wrap_setting_bits.dis == $past(sh_n[4]))
      else $error("wrap disable bit not captured");
endmodule

// file: rtl/sfw_defs.svh
`ifndef SFW_DEFS_SVH
`define SFW_DEFS_SVH
// Summary of operation
// - With wrap on, quad read output stays in an aligned 8/16/32/64-byte section.
// - Wrapped burst starts at given address, loops to section start until deselect.
// - Wrap setting affects only quad fast read and quad word read, serial mode.
// - Wrap disable bit zero enables wrapping; one gives linear reads.
// - Wrap length field 00/01/10/11 selects 8/16/32/64 byte sections.
// - Wrap disable bit powers up as one.
// - Wrap setting holds for all later quad reads until rewritten or software reset.
// - Quad word read keeps address lsb zero and uses two dummy clocks; the core takes the address as sent, without clearing the lsb.
// - Quad word read accepted only while quad enable bit is set.
// - Quad word read steps address after each byte, streaming while clocked.
// - Mode bits 10 make the next selection start at the address.
// - Other mode bit values return decoding to opcode first.
// - Identifier read: address 0 gives maker then device byte; address 1 reverses.
// - Dual identifier read works alike, two bits per clock.
// - Quad identifier read needs quad enable, address plus four dummy clocks.
// - Standard identifier read shifts out maker, memory type, capacity bytes.
// - Standard identifier opcode ignored while program or erase runs.
// - Deselect during output ends the read; device returns to standby.
// - Unique number read takes four dummy bytes, then shifts out 128 bits.
// - Quad fast read carries address, mode byte and four dummies four bits wide.
// - Software reset returns mode bits and wrap bits to power-on values.
// ==============================
// Opcodes
`define SFW_OP_WRAP 8'h77
`define SFW_OP_QFR 8'hEB
`define SFW_OP_QWR 8'hE7
`define SFW_OP_ID1 8'h90
`define SFW_OP_ID2 8'h92
`define SFW_OP_ID4 8'h94
`define SFW_OP_STDID 8'h9F
`define SFW_OP_UID 8'h4B
// ==============================
// Phase lengths in serial clocks, then the continuous-mode code
`define SFW_ADDR_CLK1 6'd24
`define SFW_ADDR_CLK2 6'd12
`define SFW_ADDR_CLK4 6'd6
`define SFW_MODE_CLK4 6'd2
`define SFW_DUM_QFR 6'd4
`define SFW_DUM_QWR 6'd2
`define SFW_DUM_ID4 6'd4
`define SFW_DUM_UID 6'd32
`define SFW_BYTE_CLK1 6'd8
`define SFW_CONT_CODE 2'h2
// ==============================
// Reset values
`define SFW_WRAP_DIS_RST 1'b1
`define SFW_WRAP_LEN_RST 2'h0
`endif

// file: rtl/sfw_pkg.sv
package sfw_pkg;
   typedef enum logic [2:0] {
      SFW_OPC, SFW_ADDR, SFW_MODE, SFW_DUMMY, SFW_DATA, SFW_WRAP, SFW_IGN
   } sfw_state_t;
   // Wrap bits: length field over disable bit
   typedef struct packed {
      logic [1:0] len;
      logic dis;
   } sfw_wrap_t;
endpackage

// file: tb/sfw_core_tb_top.sv
`include "sfw_defs.svh"
module sfw_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sfw_pkg::*;
   localparam logic [7:0] MFR = 8'hC1; // Arbitrary value
   localparam logic [7:0] DEV = 8'h2E; // Arbitrary value
   localparam logic [7:0] MTY = 8'h71; // Arbitrary value
   localparam logic [7:0] CAP = 8'h93; // Arbitrary value
   localparam logic [127:0] UID = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0; // Arbitrary value
   logic sys_clk = 1'b0;
   logic rst, cs_n, sclk, qe, busy, soft_reset, cont_mode;
   logic [3:0] io_i, io_o, io_oe;
   logic [23:0] mem_addr, a;
   logic [7:0] mem_data;
   sfw_wrap_t wrap_setting_bits;
   int failures = 0;
   int compares = 0;
   int m_dis = 1;
   int m_len = 0;
   logic [7:0] sid [3] = '{MFR, MTY, CAP};
   always #2.5 sys_clk = ~sys_clk;
   // Array contents as a function of address
   function automatic logic [7:0] memb(input int e);
      return e[7:0] ^ e[15:8] ^ 8'hA5;
   endfunction
   assign mem_data = memb(int'(mem_addr));
   sfw_core #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MTY), .CAPACITY(CAP),
         .UNIQUE_ID(UID)) sfw_core_i (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n),
         .sclk(sclk), .io_i(io_i), .io_o(io_o), .io_oe(io_oe), .quad_enable_bit(qe),
         .busy(busy), .soft_reset(soft_reset), .mem_addr(mem_addr), .mem_data(mem_data),
         .wrap_setting_bits(wrap_setting_bits), .cont_mode(cont_mode));
   sfw_host sfw_host_i (.sys_clk(sys_clk), .io_o(io_o), .io_oe(io_oe), .cs_n(cs_n),
         .sclk(sclk), .io_i(io_i));
   // ==========================
   // Checking helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Quad read against the wrap model
   task automatic qread(input logic [7:0] op, input int dum, input logic [23:0] ad,
         input logic [7:0] m, input int n);
      int s;
      int e;
      sfw_host_i.frame(op, 4, ad, 4, m, dum, 4, n);
      s = 8 << m_len;
      for (int k = 0; k < n; k++) begin
         e = m_dis != 0 ? ad + k : (ad & ~(s - 1)) | ((ad + k) & (s - 1));
         check(sfw_host_i.got[k], memb(e));
      end
      check({4'h0, sfw_host_i.oe_seen}, 8'h0F);
      check({7'h0, cont_mode}, {7'h0, m[5:4] == 2'b10});
   endtask
   task automatic set_wrap(input int dis, input int len);
      sfw_host_i.frame(`SFW_OP_WRAP, 1, 24'h0, 1, 8'((len << 5) | (dis << 4)), 0, 1, 0);
      m_dis = dis;
      m_len = len;
      check({5'h0, wrap_setting_bits}, 8'((len << 1) | dis));
   endtask
   // Watchdog
   initial begin
      #400000;
      failures++;
      complete_run();
   end
   // ==========================
   // Main sequence
   initial begin
      void'($urandom(32'hB68A));
      rst = 1'b1;
      qe = 1'b1;
      busy = 1'b0;
      soft_reset = 1'b0;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      check({5'h0, wrap_setting_bits}, 8'h01);
      for (int n = 2; n <= 4; n += 2) begin
         sfw_host_i.frame(`SFW_OP_STDID, 0, 24'h0, 0, 8'h0, 0, 1, n);
         for (int k = 0; k < n; k++) check(sfw_host_i.got[k], sid[k % 3]);
         check({4'h0, sfw_host_i.oe_seen}, 8'h02);
      end
      busy <= 1'b1;
      sfw_host_i.frame(`SFW_OP_STDID, 0, 24'h0, 0, 8'h0, 0, 1, 3);
      check({4'h0, sfw_host_i.oe_seen}, 8'h00);
      busy <= 1'b0;
      $display("done: standard id");
      for (int w = 1; w <= 4; w *= 2) begin
         for (int b = 0; b < 2; b++) begin
            sfw_host_i.frame(w == 1 ? `SFW_OP_ID1 : w == 2 ? `SFW_OP_ID2 : `SFW_OP_ID4,
                  w, 24'(b), 0, 8'h0, w == 4 ? 4 : 0, w, 4);
            for (int k = 0; k < 4; k++)
               check(sfw_host_i.got[k], (b + k) % 2 ? DEV : MFR);
         end
      end
      qe <= 1'b0;
      sfw_host_i.frame(`SFW_OP_ID4, 4, 24'h0, 0, 8'h0, 4, 4, 2);
      check({4'h0, sfw_host_i.oe_seen}, 8'h00);
      sfw_host_i.frame(`SFW_OP_QWR, 4, 24'h10, 4, 8'h0, 2, 4, 2);
      check({4'h0, sfw_host_i.oe_seen}, 8'h00);
      qe <= 1'b1;
      $display("done: id reads");
      sfw_host_i.frame(`SFW_OP_UID, 0, 24'h0, 0, 8'h0, 32, 1, 17);
      for (int k = 0; k < 17; k++) check(sfw_host_i.got[k], UID[8 * (15 - k % 16) +: 8]);
      $display("done: unique id");
      a = 24'($urandom) & 24'h0FFFFE;
      qread(`SFW_OP_QFR, 4, a, 8'h00, 12);
      for (int len = 0; len < 4; len++) begin
         set_wrap(0, len);
         qread(`SFW_OP_QWR, 2, a + 24'(len * 24'h200), 8'h00, (8 << len) + 3);
         qread(`SFW_OP_QFR, 4, a + 24'h1005, 8'h00, (8 << len) + 3);
      end
      set_wrap(1, 2);
      qread(`SFW_OP_QWR, 2, a, 8'h00, 20);
      $display("done: wrap");
      qread(`SFW_OP_QWR, 2, a, 8'h20, 4);
      qread(8'h00, 2, a + 24'h40, 8'h20, 4);
      qread(8'h00, 2, a + 24'h80, 8'h00, 4);
      qread(`SFW_OP_QWR, 2, a + 24'hC0, 8'h00, 4);
      $display("done: continuous");
      set_wrap(0, 3);
      qread(`SFW_OP_QWR, 2, a, 8'h20, 4);
      @(posedge sys_clk);
      soft_reset <= 1'b1;
      @(posedge sys_clk);
      soft_reset <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check({4'h0, wrap_setting_bits, cont_mode}, 8'h02);
      m_dis = 1;
      m_len = 0;
      qread(`SFW_OP_QWR, 2, a + 24'h3E, 8'h00, 6);
      $display("done: soft reset");
      complete_run();
   end
endmodule

// file: tb/sfw_host.sv
module sfw_host (
   input wire logic sys_clk,
   input wire logic [3:0] io_o,
   input wire logic [3:0] io_oe,
   output logic cs_n,
   output logic sclk,
   output logic [3:0] io_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   logic [3:0] oe_seen;
   // Idle: deselected, clock low
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      io_i = 4'h0;
      oe_seen = 4'h0;
   end
   // ==========================
   // Serial clock primitives
   // One clock: low phase with data, sample, rise
   task automatic xfer(input logic [3:0] d, output logic [3:0] q);
      @(posedge sys_clk);
      sclk <= 1'b0;
      io_i <= d;
      repeat (6) @(posedge sys_clk);
      q = io_o;
      oe_seen = oe_seen | io_oe;
      sclk <= 1'b1;
      repeat (5) @(posedge sys_clk);
   endtask
   // Byte out MSB first; idle lines carry noise
   task automatic send(input logic [7:0] b, input int w);
      logic [3:0] q;
      logic [3:0] mk;
      mk = 4'((1 << w) - 1);
      for (int i = 0; i < 8 / w; i++) begin
         xfer((4'(b >> (8 - w * (i + 1))) & mk) | (4'($urandom) & ~mk), q);
      end
   endtask
   // Bytes in, single width on io_o[1]
   task automatic recv(input int w, input int n);
      logic [3:0] q;
      logic [7:0] b;
      for (int k = 0; k < n; k++) begin
         for (int i = 0; i < 8 / w; i++) begin
            xfer(4'($urandom), q);
            b = w == 1 ? {b[6:0], q[1]} : w == 2 ? {b[5:0], q[1:0]} : {b[3:0], q};
         end
         got.push_back(b);
      end
   endtask
   // ==========================
   // Whole frame; opcode 00 means opcode left out
   task automatic frame(input logic [7:0] op, input int aw, input logic [23:0] a,
         input int mw, input logic [7:0] m, input int dum, input int dw,
         input int n);
      logic [3:0] q;
      got.delete();
      oe_seen = 4'h0;
      @(posedge sys_clk);
      cs_n <= 1'b0;
      if (op !== 8'h00) send(op, 1);
      for (int j = 2; j >= 0; j--) if (aw > 0) send(a[8 * j +: 8], aw);
      if (mw > 0) send(m, mw);
      repeat (dum) xfer(4'($urandom), q);
      recv(dw, n);
      @(posedge sys_clk);
      sclk <= 1'b0;
      repeat (6) @(posedge sys_clk);
      cs_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
   endtask
endmodule
